// ===== design/lbc_pkg.sv
// Package for the ladder branch condition engine: opcodes, widths, carriers
package lbc_pkg;
    localparam int TEMP_BITS    = 8;
    localparam int TEMP_IDX_W   = 3;
    localparam int ADDR_W       = 16;
    localparam logic [7:0] TEMP_RESET = 8'h00;
    localparam logic       COND_RESET = 1'b0;
    localparam logic       ILK_RESET  = 1'b0;

    typedef enum logic [3:0] {
        LBC_OP_NOP        = 4'h0,
        LBC_OP_LOAD       = 4'h1,
        LBC_OP_LOAD_NOT   = 4'h2,
        LBC_OP_AND        = 4'h3,
        LBC_OP_AND_NOT    = 4'h4,
        LBC_OP_LOAD_TEMP  = 4'h5,
        LBC_OP_OUT_TEMP   = 4'h6,
        LBC_OP_RIGHT      = 4'h7,
        LBC_OP_IL_BEGIN   = 4'h8,
        LBC_OP_IL_CLEAR   = 4'h9
    } lbc_op_t;

    // One instruction as fetched from program memory
    typedef struct packed {
        logic [ADDR_W-1:0]     addr;
        lbc_op_t               op;
        logic                  bit_status;
        logic [TEMP_IDX_W-1:0] temp_idx;
    } lbc_instr_t;

    // Result handed to the right-hand instruction executor
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              exec_cond;
        logic              forced_off;
    } lbc_result_t;
endpackage

// ===== design/lbc_temp_store.sv
// Eight single-bit temporary condition locations with registered read port
module lbc_temp_store
    import lbc_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  wr_en,
    input  wire logic [TEMP_IDX_W-1:0] wr_idx,
    input  wire logic                  wr_data,
    input  wire logic [TEMP_IDX_W-1:0] rd_idx,
    output logic                       rd_data,
    output logic [TEMP_BITS-1:0]       all_bits
);
    logic [TEMP_BITS-1:0] bits_r;
    logic [TEMP_BITS-1:0] bits_nxt;
    logic                 rd_r;
    logic                 rd_nxt;

    genvar g;
    generate
        for (g = 0; g < TEMP_BITS; g++) begin : g_bit
            always_comb begin
                bits_nxt[g] = (wr_en && wr_idx == TEMP_IDX_W'(g)) ? wr_data : bits_r[g];
            end
        end
    endgenerate

    always_comb begin
        rd_nxt = bits_r[rd_idx];
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            bits_r <= TEMP_RESET;
            rd_r   <= 1'b0;
        end else begin
            bits_r <= bits_nxt;
            rd_r   <= rd_nxt;
        end
    end

    assign rd_data  = rd_r;
    assign all_bits = bits_r;
endmodule

// ===== design/lbc_engine.sv
// Ladder branch condition engine: execution condition, temp bits, interlock
// Function
// - Eight one-bit temporary condition stores, indexed zero to seven.
// - Output to temp bit saves current condition; condition unchanged.
// - Load from temp bit restores the saved condition.
// - Load sets condition from bit status; AND combines with bit status.
// - Inverted AND combines condition with complemented bit status.
// - Instructions are expected in strictly ascending address order; a step out of order sets order_error and still executes.
// - Interlock with OFF forces OFF right-hand conditions until clear.
// - Interlock with ON leaves section conditions unmodified.
// - After interlock clear, forcing stops and normal execution resumes.
// - Several interlocks may share one clear; earlier OFF keeps forcing.
// - Later interlock OFF forces only from itself up to the clear.
// - Interlock and clear carry no operand; clear line has no conditions.
module lbc_engine
    import lbc_pkg::*;
(
    input  wire logic            sys_clk,
    input  wire logic            sys_rst,
    input  wire logic            scan_start,
    input  wire logic            instr_valid,
    input  wire lbc_instr_t      instr,
    output logic                 instr_ready,
    output logic                 result_valid,
    output lbc_result_t          result,
    output logic                 exec_cond,
    output logic                 interlock_active,
    output logic                 order_error,
    output logic [TEMP_BITS-1:0] temp_bits
);
    // Temp load takes two cycles because the store's read data is registered
    typedef enum logic [0:0] {LBC_ST_RUN, LBC_ST_TEMP_WAIT} lbc_state_t;

    lbc_state_t        state_r;
    lbc_state_t        state_nxt;
    logic              cond_r;
    logic              cond_nxt;
    logic              ilk_r;
    logic              ilk_nxt;
    logic              ilk_base;
    logic [ADDR_W-1:0] last_addr_r;
    logic [ADDR_W-1:0] last_addr_nxt;
    logic              have_addr_r;
    logic              have_addr_nxt;
    logic              err_r;
    logic              err_nxt;
    logic              res_valid_r;
    logic              res_valid_nxt;
    lbc_result_t       res_r;
    lbc_result_t       res_nxt;
    logic              tmp_wr;
    logic              tmp_rd;
    logic              take;

    // Refusing the step after a restore keeps the store's read port registered
    assign instr_ready = (state_r == LBC_ST_RUN);
    assign take        = instr_valid && instr_ready;

    lbc_temp_store u_temp (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .wr_en    (tmp_wr),
        .wr_idx   (instr.temp_idx),
        .wr_data  (cond_r),
        .rd_idx   (instr.temp_idx),
        .rd_data  (tmp_rd),
        .all_bits (temp_bits)
    );
    assign tmp_wr = take && instr.op == LBC_OP_OUT_TEMP;

    // order tracking; a new scan forgets the previous address
    always_comb begin
        last_addr_nxt = last_addr_r;
        have_addr_nxt = have_addr_r;
        err_nxt       = err_r;
        if (scan_start) begin
            have_addr_nxt = 1'b0;
            err_nxt       = 1'b0;
        end
        if (take) begin
            // A step out of order is flagged, yet still executed as written
            if (have_addr_r && !scan_start && instr.addr <= last_addr_r) begin
                err_nxt = 1'b1;
            end
            last_addr_nxt = instr.addr;
            have_addr_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            last_addr_r <= '0;
            have_addr_r <= 1'b0;
            err_r       <= 1'b0;
        end else begin
            last_addr_r <= last_addr_nxt;
            have_addr_r <= have_addr_nxt;
            err_r       <= err_nxt;
        end
    end

    // Current execution condition and the temp-restore wait
    always_comb begin
        state_nxt = state_r;
        cond_nxt  = cond_r;
        case (state_r)
            LBC_ST_RUN: begin
                if (take) begin
                    case (instr.op)
                        LBC_OP_LOAD: begin
                            cond_nxt = instr.bit_status;
                        end
                        LBC_OP_LOAD_NOT: begin
                            cond_nxt = !instr.bit_status;
                        end
                        LBC_OP_AND: begin
                            cond_nxt = cond_r && instr.bit_status;
                        end
                        LBC_OP_AND_NOT: begin
                            cond_nxt = cond_r && !instr.bit_status;
                        end
                        LBC_OP_LOAD_TEMP: begin
                            state_nxt = LBC_ST_TEMP_WAIT;
                        end
                        LBC_OP_OUT_TEMP: begin
                            cond_nxt = cond_r;
                        end
                        // Right-hand, interlock and unknown steps keep it
                        default: begin
                            cond_nxt = cond_r;
                        end
                    endcase
                end
            end
            LBC_ST_TEMP_WAIT: begin
                cond_nxt  = tmp_rd;
                state_nxt = LBC_ST_RUN;
            end
            default: begin
                state_nxt = LBC_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= LBC_ST_RUN;
            cond_r  <= COND_RESET;
        end else begin
            state_r <= state_nxt;
            cond_r  <= cond_nxt;
        end
    end

    // one interlock flag; a new scan drops it as well
    assign ilk_base = scan_start ? ILK_RESET : ilk_r;

    // An OFF interlock in the same step as a new scan still sets the flag
    always_comb begin
        ilk_nxt = ilk_base;
        if (take) begin
            case (instr.op)
                LBC_OP_IL_BEGIN: begin
                    // OFF sets; ON never clears an earlier OFF
                    if (!cond_r) begin
                        ilk_nxt = 1'b1;
                    end
                end
                // clear ends forcing, no operand used
                LBC_OP_IL_CLEAR: begin
                    ilk_nxt = 1'b0;
                end
                default: begin
                    ilk_nxt = ilk_base;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ilk_r <= ILK_RESET;
        end else begin
            ilk_r <= ilk_nxt;
        end
    end

    // right-hand result, forced OFF only while the flag is set
    always_comb begin
        res_valid_nxt = 1'b0;
        // Result keeps its last value between right-hand steps
        res_nxt       = res_r;
        if (take && instr.op == LBC_OP_RIGHT) begin
            res_valid_nxt      = 1'b1;
            res_nxt.addr       = instr.addr;
            res_nxt.exec_cond  = cond_r && !ilk_r;
            res_nxt.forced_off = ilk_r;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            res_valid_r <= 1'b0;
            res_r       <= '0;
        end else begin
            res_valid_r <= res_valid_nxt;
            res_r       <= res_nxt;
        end
    end

    assign result_valid     = res_valid_r;
    assign result           = res_r;
    assign exec_cond        = cond_r;
    assign interlock_active = ilk_r;
    assign order_error      = err_r;
endmodule

// ===== verif/lbc_engine_sva.sv
// Port assertions for the ladder branch condition engine
module lbc_engine_sva
    import lbc_pkg::*;
(
    input wire logic           sys_clk,
    input wire logic           sys_rst,
    input wire logic           instr_valid,
    input wire lbc_instr_t     instr,
    input wire logic           instr_ready,
    input wire logic           result_valid,
    input wire lbc_result_t    result,
    input wire logic           exec_cond,
    input wire logic           interlock_active,
    input wire logic [7:0]     temp_bits
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence s_take(lbc_op_t o);
        instr_valid && instr_ready && instr.op == o;
    endsequence
    a_load_sets_cond: assert property (s_take(LBC_OP_LOAD) |=> exec_cond == $past(instr.bit_status))
        else $error("load did not set the condition");
    a_and_combines: assert property (s_take(LBC_OP_AND) |=> exec_cond == ($past(exec_cond) & $past(instr.bit_status)))
        else $error("and result wrong");
    a_out_saves: assert property (s_take(LBC_OP_OUT_TEMP) |=>
        temp_bits[$past(instr.temp_idx)] == $past(exec_cond) && $stable(exec_cond)) else $error("save wrong");
    a_restore_temp: assert property (s_take(LBC_OP_LOAD_TEMP) |=>
        !instr_ready ##1 exec_cond == $past(temp_bits[instr.temp_idx], 2)) else $error("restore wrong");
    a_il_off_sets: assert property (s_take(LBC_OP_IL_BEGIN) ##0 !exec_cond |=> interlock_active)
        else $error("flag not set");
    a_forced_right: assert property (s_take(LBC_OP_RIGHT) ##0 interlock_active |=>
        result_valid && result.forced_off && !result.exec_cond) else $error("result not forced");
    a_clear_drops: assert property (s_take(LBC_OP_IL_CLEAR) |=> !interlock_active)
        else $error("flag not cleared");
    a_right_normal: assert property (s_take(LBC_OP_RIGHT) ##0 !interlock_active |=>
        result_valid && !result.forced_off && result.exec_cond == $past(exec_cond)) else $error("result wrong");
endmodule
bind lbc_engine lbc_engine_sva u_lbc_engine_sva (.sys_clk(sys_clk), .sys_rst(sys_rst), .instr_valid(instr_valid),
    .instr(instr), .instr_ready(instr_ready), .result_valid(result_valid), .result(result),
    .exec_cond(exec_cond), .interlock_active(interlock_active), .temp_bits(temp_bits));

// ===== verif/test_lbc_engine.sv
// Self-checking bench for the ladder branch condition engine
module test_lbc_engine import lbc_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        instr_valid = 1'b0;
    logic        scan_start = 1'b0;
    lbc_instr_t  instr = '0;
    logic        rdy, rv, ec, ilk, oe;
    lbc_result_t res;
    logic [7:0]  tb;
    logic [15:0] pc = 16'h0000;
    int          err_total = 0;
    int          n_compared = 0;
    always #10 sys_clk = ~sys_clk;
    lbc_engine u_lbc_engine (.sys_clk(sys_clk), .sys_rst(sys_rst), .scan_start(scan_start), .instr_valid(instr_valid),
        .instr(instr), .instr_ready(rdy), .result_valid(rv), .result(res), .exec_cond(ec),
        .interlock_active(ilk), .order_error(oe), .temp_bits(tb));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Waits out the refused cycle after a restore; address rises each time
    task automatic ex(input lbc_op_t o, input logic b = 1'b0, input logic [2:0] i = 3'h0);
        @(negedge sys_clk);
        instr_valid = 1'b1;
        instr = '{pc, o, b, i};
        pc = pc + 16'h0001;
        repeat (3) if (rdy !== 1'b1) @(negedge sys_clk);
        @(posedge sys_clk);
        #1;
    endtask
    task automatic right(input logic c, input logic f);
        ex(LBC_OP_RIGHT);
        chk({5'h00, rv, res.exec_cond, res.forced_off}, {5'h00, 1'b1, c, f});
        chk(res.addr[7:0], pc[7:0] - 8'h01);
    endtask
    task automatic t_branch();
        ex(LBC_OP_LOAD, 1'b1);
        ex(LBC_OP_OUT_TEMP);
        chk({7'h00, ec}, 8'h01);
        ex(LBC_OP_AND, 1'b0);
        right(1'b0, 1'b0);
        ex(LBC_OP_LOAD_TEMP);
        ex(LBC_OP_AND_NOT, 1'b0);
        right(1'b1, 1'b0);
        ex(LBC_OP_AND_NOT, 1'b1);
        right(1'b0, 1'b0);
        $display("branch test done");
    endtask
    task automatic t_temp();
        for (int i = 0; i < 8; i++) begin
            ex(LBC_OP_LOAD, i[0]);
            ex(LBC_OP_OUT_TEMP, 1'b0, 3'(i));
        end
        chk(tb, 8'haa);
        $display("temp test done");
    endtask
    task automatic t_il();
        ex(LBC_OP_LOAD, 1'b1);
        ex(LBC_OP_IL_BEGIN);
        ex(LBC_OP_LOAD, 1'b1);
        right(1'b1, 1'b0);
        ex(LBC_OP_LOAD, 1'b0);
        ex(LBC_OP_IL_BEGIN);
        ex(LBC_OP_LOAD, 1'b1);
        right(1'b0, 1'b1);
        ex(LBC_OP_IL_BEGIN);
        right(1'b0, 1'b1);
        ex(LBC_OP_IL_CLEAR);
        chk({7'h00, ilk}, 8'h00);
        ex(LBC_OP_LOAD, 1'b1);
        right(1'b1, 1'b0);
        $display("interlock test done");
    endtask
    // Address going backwards, then a new scan clearing order error and flag
    task automatic t_scan();
        pc = 16'h0000;
        ex(LBC_OP_LOAD_NOT, 1'b1);
        chk({6'h00, oe, ec}, 8'h02);
        ex(LBC_OP_IL_BEGIN);
        chk({7'h00, ilk}, 8'h01);
        @(negedge sys_clk);
        instr_valid = 1'b0;
        scan_start = 1'b1;
        @(negedge sys_clk);
        scan_start = 1'b0;
        chk({6'h00, oe, ilk}, 8'h00);
        ex(LBC_OP_LOAD_NOT, 1'b0);
        chk({6'h00, oe, ec}, 8'h01);
        $display("scan test done");
    endtask
    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        @(negedge sys_clk);
        sys_rst = 1'b0;
        t_branch();
        t_temp();
        t_il();
        t_scan();
        end_sim();
    end
    // About 40 instructions are issued; this span leaves a wide margin
    initial begin
        repeat (2000) @(posedge sys_clk);
        err_total++;
        end_sim();
    end
endmodule
